// [rtl/mpl_pkg.sv]
// constants, types and timing for the mii port with management link
package mpl_pkg;
   localparam int          NIB_W          = 4;
   localparam int          CLK_PERIOD_NS  = 10;
   localparam int          MDC_PERIOD_NS  = 400;
   localparam int          MDC_HALF_CYC   = MDC_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam int          MDC_CNT_W      = 5;
   localparam int          MDIO_BITS      = 64;
   localparam logic [5:0]  MDIO_LAST_BIT  = 6'h3F;
   localparam logic [5:0]  MDIO_START_BIT = 6'h20;
   localparam logic [5:0]  MDIO_TA_BIT    = 6'h2E;
   localparam logic [5:0]  MDIO_DATA_BIT  = 6'h30;
   localparam logic [31:0] MDIO_PREAMBLE  = 32'hFFFF_FFFF;
   localparam logic [1:0]  MDIO_START     = 2'h1;
   localparam logic [1:0]  MDIO_OP_WR     = 2'h1;
   localparam logic [1:0]  MDIO_OP_RD     = 2'h2;
   localparam logic [1:0]  MDIO_TA_WR     = 2'h2;
   localparam logic [3:0]  NIB_SFD        = 4'hD;
   localparam logic [3:0]  DA_NIBBLES     = 4'hC;
   localparam int          RXB_W          = 5;
   localparam int          RXB_DEPTH      = 2;
   localparam int          SYNC_W         = 11;
   localparam int          SY_TXC         = 0;
   localparam int          SY_RXC         = 1;
   localparam int          SY_DV          = 2;
   localparam int          SY_COL         = 3;
   localparam int          SY_CRS         = 4;
   localparam int          SY_MDC         = 5;
   localparam int          SY_MDIO        = 6;
   localparam int          SY_RXD         = 7;
   typedef enum logic [1:0] {
      MG_IDLE  = 2'b01,
      MG_SHIFT = 2'b10
   } mpl_mg_state_t;
endpackage

// [rtl/mpl_buf.sv]
// two-entry valid/ready buffer for received nibbles
`timescale 1ns/10ps
module mpl_buf #(
   parameter int W = 5,
   parameter int D = 2
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // fill side
   input  wire logic         in_valid,
   output      logic         in_ready,
   input  wire logic [W-1:0] in_data,
   // drain side
   output      logic         out_valid,
   input  wire logic         out_ready,
   output      logic [W-1:0] out_data
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;
   localparam int CW = $clog2(D + 1);
   logic [W-1:0]  mem_q [D];
   logic [W-1:0]  mem_d [D];
   logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic          wr, rd;

   assign in_ready  = cnt_q != CW'(D);
   assign out_valid = cnt_q != '0;
   assign out_data  = mem_q[rp_q];
   assign wr        = in_valid & in_ready;
   assign rd        = out_valid & out_ready;

   always_comb begin
      mem_d = mem_q;
      wp_d  = wp_q;
      rp_d  = rp_q;
      if (wr) begin
         mem_d[wp_q] = in_data;
         wp_d        = (wp_q == AW'(D - 1)) ? '0 : wp_q + 1'b1;
      end
      if (rd) begin
         rp_d = (rp_q == AW'(D - 1)) ? '0 : rp_q + 1'b1;
      end
      cnt_d = cnt_q + CW'(wr) - CW'(rd);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < D; i++) begin
            mem_q[i] <= '0;
         end
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         mem_q <= mem_d;
         wp_q  <= wp_d;
         rp_q  <= rp_d;
         cnt_q <= cnt_d;
      end
   end
endmodule

// [rtl/mpl_port.sv]
// mii port toward an external phy with its management link
`timescale 1ns/10ps
module mpl_port (
   // clock and reset
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   // port control
   input  wire logic                     port_enable,
   input  wire logic                     fuse_disable,
   input  wire logic                     mgmt_clk_drive,
   // transmit stream
   input  wire logic                     tx_valid,
   output      logic                     tx_ready,
   input  wire logic [mpl_pkg::NIB_W-1:0] tx_data,
   // mii transmit
   input  wire logic                     tx_nibble_clock,
   output      logic [mpl_pkg::NIB_W-1:0] tx_nibble_bus,
   output      logic                     tx_frame_enable,
   // mii receive
   input  wire logic                     rx_nibble_clock,
   input  wire logic [mpl_pkg::NIB_W-1:0] rx_nibble_bus,
   input  wire logic                     rx_nibble_valid,
   input  wire logic                     collision_in,
   input  wire logic                     carrier_sense_in,
   // receive stream
   output      logic                     rx_out_valid,
   input  wire logic                     rx_out_ready,
   output      logic [mpl_pkg::NIB_W-1:0] rx_out_data,
   output      logic                     rx_out_first,
   output      logic                     rx_overrun,
   // status
   output      logic                     port_active,
   output      logic                     collision_seen,
   output      logic                     carrier_seen,
   output      logic [mpl_pkg::NIB_W-1:0] da_hash,
   output      logic                     da_hash_valid,
   // management request
   input  wire logic                     mg_req_valid,
   output      logic                     mg_req_ready,
   input  wire logic                     mg_req_read,
   input  wire logic [4:0]               mg_req_phy,
   input  wire logic [4:0]               mg_req_reg,
   input  wire logic [15:0]              mg_req_wdata,
   output      logic [15:0]              mg_rdata,
   output      logic                     mg_done,
   // management pins
   input  wire logic                     mgmt_clock_pin_i,
   output      logic                     mgmt_clock_pin_o,
   output      logic                     mgmt_clock_pin_oe,
   input  wire logic                     mgmt_data_line_i,
   output      logic                     mgmt_data_line_o,
   output      logic                     mgmt_data_line_oe
);
   import mpl_pkg::*;

   // every pin input passes two flops; sy3 only feeds edge detectors
   logic [SYNC_W-1:0] sy_in, sy1_q, sy2_q, sy3_q;
   assign sy_in = {rx_nibble_bus, mgmt_data_line_i, mgmt_clock_pin_i, carrier_sense_in,
                   collision_in, rx_nibble_valid, rx_nibble_clock, tx_nibble_clock};

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sy1_q <= '0;
         sy2_q <= '0;
         sy3_q <= '0;
      end else begin
         sy1_q <= sy_in;
         sy2_q <= sy1_q;
         sy3_q <= sy2_q;
      end
   end

   logic txc_rise, rxc_fall;
   assign txc_rise = sy2_q[SY_TXC] & ~sy3_q[SY_TXC];
   // phy launches rx data on the rising edge, so the falling edge sits mid-nibble
   assign rxc_fall = ~sy2_q[SY_RXC] & sy3_q[SY_RXC];

   // fuse strap caught once after reset release
   logic fuse_cap_q, fuse_cap_d, fuse_q, fuse_d, port_on_q, port_on_d;
   always_comb begin
      fuse_cap_d = 1'b1;
      fuse_d     = fuse_cap_q ? fuse_q : fuse_disable;
      port_on_d  = port_enable & fuse_cap_q & ~fuse_q;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fuse_cap_q <= 1'b0;
         fuse_q     <= 1'b0;
         port_on_q  <= 1'b0;
      end else begin
         fuse_cap_q <= fuse_cap_d;
         fuse_q     <= fuse_d;
         port_on_q  <= port_on_d;
      end
   end
   assign port_active = port_on_q;

   // transmit: one nibble per rising tx clock edge, enable follows the stream
   logic [NIB_W-1:0] txd_q, txd_d;
   logic             txe_q, txe_d;
   assign tx_ready = port_on_q & txc_rise;
   always_comb begin
      txd_d = txd_q;
      txe_d = txe_q;
      if (!port_on_q) begin
         txd_d = '0;
         txe_d = 1'b0;
      end else if (txc_rise) begin
         txe_d = tx_valid;
         txd_d = tx_valid ? tx_data : '0;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         txd_q <= '0;
         txe_q <= 1'b0;
      end else begin
         txd_q <= txd_d;
         txe_q <= txe_d;
      end
   end
   assign tx_nibble_bus   = txd_q;
   assign tx_frame_enable = txe_q;

   // receive: capture, address hash and status
   logic             sample, dv, push, buf_in_ready;
   logic [NIB_W-1:0] rxd;
   logic             dvp_q, dvp_d, sfd_q, sfd_d, hv_q, hv_d, ovr_q, ovr_d;
   logic             col_q, col_d, crs_q, crs_d;
   logic [3:0]       dac_q, dac_d;
   logic [NIB_W-1:0] hash_q, hash_d;
   assign sample = rxc_fall & port_on_q;
   assign dv     = sy2_q[SY_DV];
   assign rxd    = sy2_q[SY_RXD +: NIB_W];
   assign push   = sample & dv;
   always_comb begin
      dvp_d  = port_on_q ? (sample ? dv : dvp_q) : 1'b0;
      sfd_d  = sfd_q;
      dac_d  = dac_q;
      hash_d = hash_q;
      hv_d   = 1'b0;
      ovr_d  = push & ~buf_in_ready;
      col_d  = port_on_q & sy2_q[SY_COL];
      crs_d  = port_on_q & sy2_q[SY_CRS];
      if (push & ~dvp_q) begin
         sfd_d  = 1'b0;
         dac_d  = '0;
         hash_d = '0;
      end
      if (push & ~sfd_q & (rxd == NIB_SFD) & dvp_q) begin
         sfd_d = 1'b1;
      end else if (push & sfd_q & (dac_q != DA_NIBBLES)) begin
         hash_d = {hash_q[NIB_W-2:0], hash_q[NIB_W-1]} ^ rxd;
         dac_d  = dac_q + 4'h1;
         hv_d   = dac_q == DA_NIBBLES - 4'h1;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dvp_q  <= 1'b0;
         sfd_q  <= 1'b0;
         dac_q  <= '0;
         hash_q <= '0;
         hv_q   <= 1'b0;
         ovr_q  <= 1'b0;
         col_q  <= 1'b0;
         crs_q  <= 1'b0;
      end else begin
         dvp_q  <= dvp_d;
         sfd_q  <= sfd_d;
         dac_q  <= dac_d;
         hash_q <= hash_d;
         hv_q   <= hv_d;
         ovr_q  <= ovr_d;
         col_q  <= col_d;
         crs_q  <= crs_d;
      end
   end
   assign da_hash        = hash_q;
   assign da_hash_valid  = hv_q;
   assign rx_overrun     = ovr_q;
   assign collision_seen = col_q;
   assign carrier_seen   = crs_q;

   logic [RXB_W-1:0] buf_out;
   mpl_buf #(.W(RXB_W), .D(RXB_DEPTH)) u_rxbuf (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (push),
      .in_ready  (buf_in_ready),
      .in_data   ({~dvp_q, rxd}),
      .out_valid (rx_out_valid),
      .out_ready (rx_out_ready),
      .out_data  (buf_out)
   );
   assign rx_out_data  = buf_out[NIB_W-1:0];
   assign rx_out_first = buf_out[NIB_W];

   // management: own divider when driving the clock, else edges of the pin
   // limitation: with the pin as input a frame waits for the far end's clock
   mpl_mg_state_t        mst_q, mst_d;
   logic [MDC_CNT_W-1:0] div_q, div_d;
   logic                 mdc_q, mdc_d, drv_q, drv_d, rd_q, rd_d, done_q, done_d;
   logic [MDIO_BITS-1:0] sh_q, sh_d;
   logic [5:0]           cnt_q, cnt_d;
   logic [15:0]          rdat_q, rdat_d;
   logic                 tick, mdc_rise, mdc_fall;
   assign tick     = drv_q & (div_q == MDC_CNT_W'(MDC_HALF_CYC - 1));
   assign mdc_rise = drv_q ? (tick & ~mdc_q) : (sy2_q[SY_MDC] & ~sy3_q[SY_MDC]);
   assign mdc_fall = drv_q ? (tick & mdc_q) : (~sy2_q[SY_MDC] & sy3_q[SY_MDC]);
   always_comb begin
      drv_d  = mgmt_clk_drive;
      div_d  = (!drv_q || tick) ? '0 : div_q + 1'b1;
      mdc_d  = drv_q ? (mdc_q ^ tick) : 1'b0;
      mst_d  = mst_q;
      sh_d   = sh_q;
      cnt_d  = cnt_q;
      rd_d   = rd_q;
      rdat_d = rdat_q;
      done_d = 1'b0;
      unique case (mst_q)
         MG_IDLE: begin
            if (mg_req_valid) begin
               sh_d  = {MDIO_PREAMBLE, MDIO_START, mg_req_read ? MDIO_OP_RD : MDIO_OP_WR,
                        mg_req_phy, mg_req_reg, MDIO_TA_WR, mg_req_wdata};
               cnt_d = '0;
               rd_d  = mg_req_read;
               mst_d = MG_SHIFT;
            end
         end
         MG_SHIFT: begin
            if (mdc_rise && rd_q && cnt_q >= MDIO_DATA_BIT) begin
               rdat_d = {rdat_q[14:0], sy2_q[SY_MDIO]};
            end
            if (mdc_fall) begin
               if (cnt_q == MDIO_LAST_BIT) begin
                  mst_d  = MG_IDLE;
                  done_d = 1'b1;
               end else begin
                  cnt_d = cnt_q + 6'h01;
                  sh_d  = {sh_q[MDIO_BITS-2:0], 1'b1};
               end
            end
         end
         default: mst_d = MG_IDLE;
      endcase
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mst_q  <= MG_IDLE;
         div_q  <= '0;
         mdc_q  <= 1'b0;
         drv_q  <= 1'b0;
         sh_q   <= '1;
         cnt_q  <= '0;
         rd_q   <= 1'b0;
         rdat_q <= '0;
         done_q <= 1'b0;
      end else begin
         mst_q  <= mst_d;
         div_q  <= div_d;
         mdc_q  <= mdc_d;
         drv_q  <= drv_d;
         sh_q   <= sh_d;
         cnt_q  <= cnt_d;
         rd_q   <= rd_d;
         rdat_q <= rdat_d;
         done_q <= done_d;
      end
   end
   assign mg_req_ready      = mst_q == MG_IDLE;
   assign mg_rdata          = rdat_q;
   assign mg_done           = done_q;
   assign mgmt_clock_pin_o  = mdc_q;
   assign mgmt_clock_pin_oe = drv_q;
   assign mgmt_data_line_o  = sh_q[MDIO_BITS-1];
   // read frames release the line from turnaround on
   assign mgmt_data_line_oe = (mst_q == MG_SHIFT) && (!rd_q || cnt_q < MDIO_TA_BIT);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_tx_off_low: assert property (!port_on_q |=> !tx_frame_enable && tx_nibble_bus == '0)
      else $error("tx outputs active while port off");
   a_tx_nibble_launch: assert property (tx_ready && tx_valid |=>
      tx_frame_enable && tx_nibble_bus == $past(tx_data))
      else $error("tx nibble not launched");
   a_txen_holds: assert property (tx_frame_enable && port_on_q && !txc_rise |=> tx_frame_enable)
      else $error("tx enable dropped between edges");
   a_rx_valid_only: assert property ($rose(rx_out_valid) |-> $past(push) && $past(dv))
      else $error("rx data without valid");
   a_rx_quiet_off: assert property (!port_on_q [*2] |-> !collision_seen && !da_hash_valid)
      else $error("rx status while port off");
   a_crs_synced: assert property (carrier_seen |-> $past(carrier_sense_in, 3))
      else $error("carrier seen without synchronised input");
   a_fuse_blocks: assert property (fuse_q && fuse_cap_q |=> !port_active)
      else $error("port active with fuse set");
   a_mdc_input: assert property (!mgmt_clk_drive |=> !mgmt_clock_pin_oe)
      else $error("management clock driven while input");
   a_mdio_launch: assert property (mdc_fall && mst_q == MG_SHIFT && cnt_q != MDIO_LAST_BIT |=>
      mgmt_data_line_o == $past(sh_q[MDIO_BITS-2]))
      else $error("management bit not launched on falling clock");
   a_mdio_release: assert property (mst_q == MG_SHIFT && rd_q && cnt_q >= MDIO_TA_BIT |->
      !mgmt_data_line_oe)
      else $error("data line driven during read data");
   a_mdio_start: assert property (mst_q == MG_SHIFT && cnt_q == MDIO_START_BIT |->
      mgmt_data_line_o == 1'b0 && mgmt_data_line_oe)
      else $error("start bit wrong");
   a_hash_count: assert property (da_hash_valid |-> dac_q == DA_NIBBLES)
      else $error("hash done at wrong nibble");

   c_tx_frame: cover property (tx_frame_enable ##1 !tx_frame_enable);
   c_rx_first: cover property (rx_out_valid && rx_out_first && rx_out_ready);
   c_mdio_read: cover property (mg_done && rd_q);
   c_rx_overrun: cover property (rx_overrun);
endmodule

// [verification/mpl_phy_model.sv]
// phy-side model: free-running mii clocks, frame source, transmit capture, management responder
`timescale 1ns/10ps
module mpl_phy_model #(
   parameter int HALF_NS = 40
) (
   // mii transmit
   output      logic       tx_nibble_clock,
   input  wire logic [3:0] tx_nibble_bus,
   input  wire logic       tx_frame_enable,
   // mii receive
   output      logic       rx_nibble_clock,
   output      logic [3:0] rx_nibble_bus,
   output      logic       rx_nibble_valid,
   output      logic       collision_in,
   output      logic       carrier_sense_in,
   // management pins
   input  wire logic       mdc,
   input  wire logic       mdio,
   output      logic       mdio_o,
   output      logic       mdio_oe
);
   logic [3:0]  tx_cap[$];
   logic [29:0] mg_cap[$];
   logic [15:0] rd_val;
   logic [33:0] sh;
   logic        act;
   logic        rd;
   int          idx;
   initial begin
      {tx_nibble_clock, rx_nibble_clock, rx_nibble_valid, collision_in} = '0;
      {carrier_sense_in, mdio_o, mdio_oe, act, rd} = '0;
      rx_nibble_bus = 4'hA;
      sh = '0;
      idx = 0;
      rd_val = 16'h0000;
   end
   // phy clocks run free; rx trails tx by a quarter period
   always #(HALF_NS) tx_nibble_clock = ~tx_nibble_clock;
   initial begin
      #(HALF_NS / 2);
      forever #(HALF_NS) rx_nibble_clock = ~rx_nibble_clock;
   end
   // idle data is noise so a stale nibble can never pass for frame data
   always @(negedge rx_nibble_clock) if (!rx_nibble_valid) rx_nibble_bus <= ~rx_nibble_bus;
   always @(posedge tx_nibble_clock) if (tx_frame_enable === 1'b1) tx_cap.push_back(tx_nibble_bus);
   task automatic send(input logic [3:0] q[$]);
      carrier_sense_in = 1'b1;
      foreach (q[i]) begin
         @(posedge rx_nibble_clock);
         rx_nibble_valid <= 1'b1;
         rx_nibble_bus   <= q[i];
      end
      @(posedge rx_nibble_clock);
      rx_nibble_valid  <= 1'b0;
      carrier_sense_in <= 1'b0;
   endtask
   task automatic collide();
      #13;
      carrier_sense_in = 1'b1;
      collision_in     = 1'b1;
      repeat (4) @(posedge rx_nibble_clock);
      collision_in     <= 1'b0;
      carrier_sense_in <= 1'b0;
   endtask
   // a frame starts only after 32 ones then 01, as a real phy must see it
   always @(posedge mdc) begin
      sh = {sh[32:0], mdio};
      if (act) begin
         idx++;
         if (idx == 35) rd = (sh[1:0] == 2'b10);
         if (idx == 63) begin
            mg_cap.push_back(sh[29:0]);
            act = 1'b0;
         end
      end else if (sh == {32'hFFFF_FFFF, 2'b01}) begin
         act = 1'b1;
         idx = 33;
      end
   end
   // read: second turnaround bit low, then data msb first, launched on mdc fall
   always @(negedge mdc) begin
      mdio_oe = act && rd && idx >= 46;
      mdio_o  = (idx == 46) ? 1'b0 : rd_val[(62 - idx) & 15];
   end
endmodule

// [verification/mpl_port_tb.sv]
// self-checking bench: mii port against a phy model and a queue-based reference
`timescale 1ns/10ps
module mpl_port_tb;
   import mpl_pkg::*;
   logic        clk, rst_n, port_enable, fuse_disable, mgmt_clk_drive, stall;
   logic        tx_valid, tx_ready, tx_frame_enable, tx_nibble_clock, rx_nibble_clock;
   logic [3:0]  tx_data, tx_nibble_bus, rx_nibble_bus, rx_out_data, da_hash, hash_exp;
   logic        rx_nibble_valid, collision_in, carrier_sense_in, rx_out_valid, rx_out_ready;
   logic        rx_out_first, rx_overrun, port_active, collision_seen, carrier_seen;
   logic        da_hash_valid, mg_req_valid, mg_req_ready, mg_req_read, mg_done;
   logic [4:0]  mg_req_phy, mg_req_reg;
   logic [15:0] mg_req_wdata, mg_rdata, lf;
   logic        mdc_o, mdc_oe, md_o, md_oe, phy_o, phy_oe, mdc_w, mdio_w;
   logic [4:0]  rx_exp[$];
   logic [3:0]  q[$];
   int          err_total, samples_checked, ovr_cnt, hash_seen;
   mpl_port i_dut (
      .clk, .rst_n, .port_enable, .fuse_disable, .mgmt_clk_drive,
      .tx_valid, .tx_ready, .tx_data, .tx_nibble_clock, .tx_nibble_bus, .tx_frame_enable,
      .rx_nibble_clock, .rx_nibble_bus, .rx_nibble_valid, .collision_in, .carrier_sense_in,
      .rx_out_valid, .rx_out_ready, .rx_out_data, .rx_out_first, .rx_overrun,
      .port_active, .collision_seen, .carrier_seen, .da_hash, .da_hash_valid,
      .mg_req_valid, .mg_req_ready, .mg_req_read, .mg_req_phy, .mg_req_reg,
      .mg_req_wdata, .mg_rdata, .mg_done,
      .mgmt_clock_pin_i(mdc_w), .mgmt_clock_pin_o(mdc_o), .mgmt_clock_pin_oe(mdc_oe),
      .mgmt_data_line_i(mdio_w), .mgmt_data_line_o(md_o), .mgmt_data_line_oe(md_oe)
   );
   mpl_phy_model i_phy (
      .tx_nibble_clock, .tx_nibble_bus, .tx_frame_enable, .rx_nibble_clock, .rx_nibble_bus,
      .rx_nibble_valid, .collision_in, .carrier_sense_in,
      .mdc(mdc_w), .mdio(mdio_w), .mdio_o(phy_o), .mdio_oe(phy_oe)
   );
   // released pins idle high through their pull-ups
   assign mdc_w  = (mdc_oe === 1'b1) ? mdc_o : 1'b1;
   assign mdio_w = (md_oe === 1'b1) ? md_o : ((phy_oe === 1'b1) ? phy_o : 1'b1);
   always #5 clk = ~clk;
   function automatic logic [3:0] rnd();
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      return lf[3:0];
   endfunction
   task automatic chk_flag(input logic got, input logic exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask
   task automatic chk_word(input logic [29:0] got, input logic [29:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic summarize();
      if (err_total == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic do_reset(input logic fuse);
      rst_n = 1'b0;
      fuse_disable = fuse;
      step(20);
      chk_flag(tx_frame_enable | (|tx_nibble_bus), 1'b0, "tx idle in reset");
      chk_flag(mdc_oe | md_oe, 1'b0, "mgmt pins released in reset");
      rst_n = 1'b1;
   endtask
   task automatic tx_frame();
      int n;
      foreach (q[i]) begin
         tx_valid = 1'b1;
         tx_data  = q[i];
         n = 0;
         do begin
            @(negedge clk);
            n++;
         end while (tx_ready !== 1'b1 && n < 40);
         chk_flag(tx_ready, 1'b1, "tx ready timeout");
         step(1);
      end
      tx_valid = 1'b0;
   endtask
   task automatic mg_op(input logic rd, input logic [4:0] phy, input logic [4:0] ra);
      logic [15:0] wd;
      logic [29:0] fr;
      int          n;
      wd = {rnd(), rnd(), rnd(), rnd()};
      i_phy.rd_val = {rnd(), rnd(), rnd(), rnd()};
      {mg_req_valid, mg_req_read, mg_req_phy, mg_req_reg, mg_req_wdata} = {1'b1, rd, phy, ra, wd};
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (mg_req_ready !== 1'b1 && n < 40);
      chk_flag(mg_req_ready, 1'b1, "mgmt ready timeout");
      step(1);
      mg_req_valid = 1'b0;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (mg_done !== 1'b1 && n < 4000);
      chk_flag(mg_done, 1'b1, "mgmt done timeout");
      step(1);
      fr = {rd ? 2'b10 : 2'b01, phy, ra, 2'b10, rd ? i_phy.rd_val : wd};
      if (i_phy.mg_cap.size() == 0) chk_flag(1'b1, 1'b0, "no management frame");
      else chk_word(i_phy.mg_cap.pop_front(), fr, "management frame");
      if (rd) chk_word(30'(mg_rdata), 30'(i_phy.rd_val), "read data");
   endtask
   // reference for the receive stream, checked where the handshake is settled
   always @(negedge clk) begin
      if (rx_out_valid === 1'b1 && rx_out_ready === 1'b1) begin
         if (rx_exp.size() == 0) chk_flag(1'b1, 1'b0, "rx nibble not expected");
         else chk_word(30'({rx_out_first, rx_out_data}), 30'(rx_exp.pop_front()), "rx");
      end
      if (rx_overrun === 1'b1) ovr_cnt++;
      if (da_hash_valid === 1'b1) begin
         hash_seen++;
         chk_word(30'(da_hash), 30'(hash_exp), "address hash");
      end
      if (md_oe === 1'b1 && phy_oe === 1'b1) chk_flag(1'b1, 1'b0, "data line contention");
   end
   // random receiver stalls, moved just after the edge like every other input
   always @(posedge clk) rx_out_ready <= #1 !stall && (rnd() > 4'h7);
   initial begin
      clk = 1'b0;
      lf = 16'h61AB;
      {port_enable, mgmt_clk_drive, tx_valid, mg_req_valid, mg_req_read, stall} = '0;
      {tx_data, mg_req_phy, mg_req_reg, mg_req_wdata, hash_exp} = '0;
      rx_out_ready = 1'b0;
      err_total = 0;
      samples_checked = 0;
      ovr_cnt = 0;
      hash_seen = 0;
      // fused off: nothing may pass even with software enable and traffic present
      do_reset(1'b1);
      port_enable = 1'b1;
      tx_valid = 1'b1;
      q = '{4'h5, 4'h5, 4'h5, 4'hD, 4'h1, 4'h2};
      fork
         i_phy.send(q);
         repeat (70) begin
            @(negedge clk);
            chk_flag(port_active | tx_ready | tx_frame_enable | carrier_seen, 1'b0, "fused");
         end
      join
      tx_valid = 1'b0;
      step(1);
      do_reset(1'b0);
      step(3);
      chk_flag(port_active, 1'b1, "port active");
      mgmt_clk_drive = 1'b1;
      step(3);
      chk_flag(mdc_oe, 1'b1, "mgmt clock driven");
      q = {};
      repeat (15) q.push_back(4'h5);
      q.push_back(4'hD);
      repeat (16) q.push_back(rnd());
      foreach (q[i]) begin
         rx_exp.push_back({i == 0, q[i]});
         if (i > 15 && i < 28) hash_exp = {hash_exp[2:0], hash_exp[3]} ^ q[i];
      end
      i_phy.send(q);
      step(20);
      chk_word(30'(rx_exp.size()), 30'h0, "rx frame drained");
      chk_word(30'(hash_seen), 30'h1, "one hash per frame");
      // receiver stalls through a whole burst: two entries kept, the rest dropped
      stall = 1'b1;
      step(2);
      q = '{4'h5, 4'h5, 4'h5, 4'h5, 4'h5, 4'h5};
      rx_exp = '{5'h15, 5'h05};
      ovr_cnt = 0;
      i_phy.send(q);
      step(20);
      chk_word(30'(ovr_cnt), 30'h4, "dropped nibbles");
      stall = 1'b0;
      step(20);
      chk_word(30'(rx_exp.size()), 30'h0, "buffer drained");
      fork
         i_phy.collide();
         begin
            step(12);
            chk_flag(collision_seen, 1'b1, "collision seen");
            chk_flag(carrier_seen, 1'b1, "carrier seen");
         end
      join
      step(12);
      chk_flag(collision_seen | carrier_seen, 1'b0, "medium idle");
      q = {};
      repeat (15) q.push_back(4'h5);
      q.push_back(4'hD);
      repeat (20) q.push_back(rnd());
      tx_frame();
      step(20);
      chk_flag(tx_frame_enable, 1'b0, "tx enable drops after frame");
      chk_word(30'(i_phy.tx_cap.size()), 30'(q.size()), "tx nibble count");
      foreach (q[i]) chk_word(30'(i_phy.tx_cap[i]), 30'(q[i]), "tx nibble");
      mg_op(1'b0, 5'h01, 5'h00);
      mg_op(1'b1, 5'h1F, 5'h1F);
      mg_op(1'b0, 5'h00, 5'h1F);
      summarize();
   end
   initial begin
      #500_000;
      err_total++;
      summarize();
   end
endmodule
